// File: hw/afc_pkg.sv
// Constants and carrier types for the front-end slot configuration bank.
// Assumes a word-wide register port fed by the serial host interface.
package afc_pkg;

    // Register addresses
    localparam logic [7:0] AFC_ADDR_B_POLARITY = 8'h1d;
    localparam logic [7:0] AFC_ADDR_B_WINDOW = 8'h3b;
    localparam logic [7:0] AFC_ADDR_A_MODE = 8'h42;
    localparam logic [7:0] AFC_ADDR_A_PATH = 8'h43;
    localparam logic [7:0] AFC_ADDR_B_MODE = 8'h44;

    // Reset values
    localparam logic [15:0] AFC_RST_B_POLARITY = 16'h0000;
    localparam logic [15:0] AFC_RST_B_WINDOW = 16'h2017;
    localparam logic [15:0] AFC_RST_A_MODE = 16'h1c38;
    localparam logic [15:0] AFC_RST_A_PATH = 16'hada5;
    localparam logic [15:0] AFC_RST_B_MODE = 16'h1c38;

    // Field positions
    localparam int AFC_POL_MSB = 3;
    localparam int AFC_WIN_LEN_MSB = 15;
    localparam int AFC_WIN_LEN_LSB = 11;
    localparam int AFC_WIN_DLY_MSB = 10;
    localparam int AFC_BUF_GAIN_BIT = 9;
    localparam int AFC_BYPASS_BIT = 7;
    localparam int AFC_PER_CH_BIT = 6;
    localparam int AFC_VREF_MSB = 5;
    localparam int AFC_VREF_LSB = 4;
    localparam int AFC_GAIN_MSB = 1;

    // Path selection codes
    localparam logic [15:0] AFC_PATH_CODE_FULL = 16'hada5;
    localparam logic [15:0] AFC_PATH_CODE_TIA_BUF = 16'hae65;
    localparam logic [15:0] AFC_PATH_CODE_TIA_DIRECT = 16'hb065;

    // Step sizes of the window fields and their cost at the 40 MHz core clock
    localparam int AFC_CLK_PERIOD_PS = 25000;
    localparam int AFC_WIN_LEN_STEP_NS = 1000;
    localparam int AFC_WIN_DLY_STEP_PS = 31250;
    localparam int AFC_WIN_LEN_STEP_CYC = (AFC_WIN_LEN_STEP_NS * 1000) / AFC_CLK_PERIOD_PS;

    typedef enum logic [1:0] {
        AFC_PATH_FULL,
        AFC_PATH_TIA_BUF,
        AFC_PATH_TIA_DIRECT,
        AFC_PATH_RESERVED
    } afc_path_e;

    // Whole register bank, one flop set
    typedef struct packed {
        logic [15:0] b_polarity;
        logic [15:0] b_window;
        logic [15:0] a_mode;
        logic [15:0] a_path;
        logic [15:0] b_mode;
        logic [15:0] rdata;
        logic rvalid;
    } afc_regs_s;

    // Decoded settings of one slot
    typedef struct packed {
        logic [7:0] gains;
        logic [1:0] amp_reference_sel;
        logic integrator_bypass;
        logic buffer_gain_sel;
        logic per_channel_gain_on;
    } afc_slot_s;

    typedef struct packed {
        logic [1:0] next_pulse;
        logic reverse;
    } afc_pol_s;

endpackage : afc_pkg

// File: hw/afc_pulse_polarity.sv
// Per-pulse integration polarity stepper for slot B.
// Assumes the sequencer strobes one pulse per cycle at most.
module afc_pulse_polarity (
    // Clock, reset and enable
    input wire logic i_clk,
    input wire logic i_reset,
    input wire logic i_ce,
    // Sequence strobes and polarity order
    input wire logic i_seq_start,
    input wire logic i_pulse,
    input wire logic [3:0] i_order,
    // Polarity of the pulse just strobed, index of the next pulse
    output logic o_reverse,
    output logic [1:0] o_next_pulse
);
    afc_pkg::afc_pol_s st;
    afc_pkg::afc_pol_s next_st;
    logic [1:0] idx;

    always_comb begin
        next_st = st;
        idx = i_seq_start ? 2'h0 : st.next_pulse;
        if (i_seq_start) begin
            next_st.next_pulse = 2'h0;
        end
        if (i_pulse) begin
            next_st.reverse = i_order[idx];
            next_st.next_pulse = 2'(idx + 2'h1);    // Wraps after pulse 4
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_reset) begin
            st <= '0;
        end else if (i_ce) begin
            st <= next_st;
        end
    end

    assign o_reverse = st.reverse;
    assign o_next_pulse = st.next_pulse;
endmodule : afc_pulse_polarity

// File: hw/afc_slot_config.sv
// Front-end configuration register bank for the two measurement slots.
// Assumes the serial host decoder hands over one 16-bit word access per strobe.
// Notes on behaviour
// - Slot B polarity is four bits, bit n for pulse n+1, repeating.
// - Slot B window length is bits 15:11, 1 us steps, reset 4.
// - Slot B window delay is bits 10:0, 31.25 ns steps, reset 0x17.
// - Slot B mode bit 9 picks buffer gain 1 or 0.7.
// - Slot B mode bit 7 makes integrator a buffer; only for TIA-to-converter.
// - Slot B bit 6 on: ch1 own gain, ch2-4 from per-channel word bits 11:6.
// - Slot B reference select bits 5:4, reset 3, four reference voltages.
// - Slot A gain code 200k..25k; all channels or only ch1.
// - Slot A path word resets 0xADA5; unknown codes are reserved.
// - Slot A mode bit 7 turns the integrator into a buffer.
module afc_slot_config (
    // Clock, reset, enable
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CORE_CE,
    // Register port
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    output logic [15:0] O_REG_RDATA,
    output logic O_REG_RVALID,
    // Per-channel gain word held elsewhere
    input wire logic [11:0] I_CH_GAIN_WORD,
    // Slot B pulse sequencing
    input wire logic I_SLOTB_SEQ_START,
    input wire logic I_SLOTB_PULSE,
    output logic O_SLOTB_REVERSE,
    // Decoded slot settings
    output afc_pkg::afc_slot_s O_SLOTA,
    output afc_pkg::afc_slot_s O_SLOTB,
    output logic [4:0] O_SLOTB_WINDOW_LENGTH,
    output logic [10:0] O_SLOTB_WINDOW_DELAY,
    output logic [12:0] O_SLOTB_WINDOW_LENGTH_CYC,
    output afc_pkg::afc_path_e O_SLOTA_PATH,
    output logic O_SLOTA_PATH_MISMATCH
);
    afc_pkg::afc_regs_s r;
    afc_pkg::afc_regs_s next_r;
    afc_pkg::afc_slot_s next_a;
    afc_pkg::afc_slot_s next_b;
    afc_pkg::afc_path_e next_path;

    // Channel 1 keeps its own code; others follow it unless split
    function automatic logic [7:0] fan_gain(input logic split, input logic [1:0] own,
                                            input logic [5:0] others);
        logic [7:0] g;
        g = split ? {others, own} : {own, own, own, own};
        return g;
    endfunction : fan_gain

    function automatic afc_pkg::afc_slot_s decode_mode(input logic [15:0] mode,
                                                       input logic [5:0] others);
        afc_pkg::afc_slot_s s;
        s.per_channel_gain_on = mode[afc_pkg::AFC_PER_CH_BIT];
        s.gains = fan_gain(s.per_channel_gain_on, mode[afc_pkg::AFC_GAIN_MSB:0], others);
        s.amp_reference_sel = mode[afc_pkg::AFC_VREF_MSB:afc_pkg::AFC_VREF_LSB];
        s.integrator_bypass = mode[afc_pkg::AFC_BYPASS_BIT];
        s.buffer_gain_sel = mode[afc_pkg::AFC_BUF_GAIN_BIT];
        return s;
    endfunction : decode_mode

    always_comb begin
        next_r = r;
        next_r.rvalid = 1'b0;
        // Whole word stored, reserved bits too, so readback is exact
        if (I_REG_WR) begin
            unique case (I_REG_ADDR)
                afc_pkg::AFC_ADDR_B_POLARITY: next_r.b_polarity = I_REG_WDATA;
                afc_pkg::AFC_ADDR_B_WINDOW: next_r.b_window = I_REG_WDATA;
                afc_pkg::AFC_ADDR_A_MODE: next_r.a_mode = I_REG_WDATA;
                afc_pkg::AFC_ADDR_A_PATH: next_r.a_path = I_REG_WDATA;
                afc_pkg::AFC_ADDR_B_MODE: next_r.b_mode = I_REG_WDATA;
                default: ;
            endcase
        end
        // Read returns the stored word before a same-cycle write lands
        if (I_REG_RD) begin
            next_r.rvalid = 1'b1;
            unique case (I_REG_ADDR)
                afc_pkg::AFC_ADDR_B_POLARITY: next_r.rdata = r.b_polarity;
                afc_pkg::AFC_ADDR_B_WINDOW: next_r.rdata = r.b_window;
                afc_pkg::AFC_ADDR_A_MODE: next_r.rdata = r.a_mode;
                afc_pkg::AFC_ADDR_A_PATH: next_r.rdata = r.a_path;
                afc_pkg::AFC_ADDR_B_MODE: next_r.rdata = r.b_mode;
                default: next_r.rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            r.b_polarity <= afc_pkg::AFC_RST_B_POLARITY;
            r.b_window <= afc_pkg::AFC_RST_B_WINDOW;
            r.a_mode <= afc_pkg::AFC_RST_A_MODE;
            r.a_path <= afc_pkg::AFC_RST_A_PATH;
            r.b_mode <= afc_pkg::AFC_RST_B_MODE;
            r.rdata <= 16'h0000;
            r.rvalid <= 1'b0;
        end else if (I_CORE_CE) begin
            r <= next_r;
        end
    end

    // Decoded outputs are registered so the analog side sees clean levels
    always_comb begin
        next_a = decode_mode(r.a_mode, I_CH_GAIN_WORD[5:0]);
        next_b = decode_mode(r.b_mode, I_CH_GAIN_WORD[11:6]);
        unique case (r.a_path)
            afc_pkg::AFC_PATH_CODE_FULL: next_path = afc_pkg::AFC_PATH_FULL;
            afc_pkg::AFC_PATH_CODE_TIA_BUF: next_path = afc_pkg::AFC_PATH_TIA_BUF;
            afc_pkg::AFC_PATH_CODE_TIA_DIRECT: next_path = afc_pkg::AFC_PATH_TIA_DIRECT;
            default: next_path = afc_pkg::AFC_PATH_RESERVED;
        endcase
    end

    afc_pkg::afc_slot_s slot_a;
    afc_pkg::afc_slot_s slot_b;
    afc_pkg::afc_path_e path_a;
    logic mismatch_a;

    always_ff @(posedge I_CORE_CLK) begin
        if (I_RESET) begin
            slot_a <= '0;
            slot_b <= '0;
            path_a <= afc_pkg::AFC_PATH_FULL;
            mismatch_a <= 1'b0;
        end else if (I_CORE_CE) begin
            slot_a <= next_a;
            slot_b <= next_b;
            path_a <= next_path;
            // Flags a software ordering slip only; hardware does not block it
            mismatch_a <= ((next_path == afc_pkg::AFC_PATH_TIA_BUF) && !next_a.integrator_bypass)
                || ((next_path == afc_pkg::AFC_PATH_TIA_DIRECT) && next_a.integrator_bypass);
        end
    end

    afc_pulse_polarity u_pol (
        .i_clk(I_CORE_CLK),
        .i_reset(I_RESET),
        .i_ce(I_CORE_CE),
        .i_seq_start(I_SLOTB_SEQ_START),
        .i_pulse(I_SLOTB_PULSE),
        .i_order(r.b_polarity[afc_pkg::AFC_POL_MSB:0]),
        .o_reverse(O_SLOTB_REVERSE),
        .o_next_pulse()
    );

    assign O_REG_RDATA = r.rdata;
    assign O_REG_RVALID = r.rvalid;
    assign O_SLOTA = slot_a;
    assign O_SLOTB = slot_b;
    assign O_SLOTA_PATH = path_a;
    assign O_SLOTA_PATH_MISMATCH = mismatch_a;
    assign O_SLOTB_WINDOW_LENGTH = r.b_window[afc_pkg::AFC_WIN_LEN_MSB:afc_pkg::AFC_WIN_LEN_LSB];
    assign O_SLOTB_WINDOW_DELAY = r.b_window[afc_pkg::AFC_WIN_DLY_MSB:0];
    // Length in core cycles; the delay step is not a whole cycle, so it stays raw
    assign O_SLOTB_WINDOW_LENGTH_CYC = 13'(O_SLOTB_WINDOW_LENGTH
        * 13'(afc_pkg::AFC_WIN_LEN_STEP_CYC));
endmodule : afc_slot_config

// File: verification/afc_host_model.sv
// Host software model driving the word-wide register port.
// Assumes the bench clock; requests move 2 ns after a rising edge.
module afc_host_model (
    // Register port
    input wire logic clk,
    input wire logic [15:0] rdata,
    input wire logic rvalid,
    output logic [7:0] addr,
    output logic [15:0] wdata,
    output logic wr,
    output logic rd
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        {addr, wdata, wr, rd} = 26'h0;
    end
    // Whole words only; idle lines show the inverse so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d,
        output logic [15:0] q);
        @(posedge clk);
        #2;
        {addr, wdata, wr, rd} = {a, d, w, !w};
        @(posedge clk);
        #2;
        q = (w || rvalid) ? rdata : 16'hxxxx;
        {addr, wdata, wr, rd} = {~a, ~d, 2'b00};
    endtask : xfer
endmodule : afc_host_model

// File: verification/afc_slot_config_properties.sv
// Checker for the slot configuration bank, bound to its top.
// Assumes the clock enable is high around checked accesses.
module afc_slot_config_chk (
    // Watched ports
    input wire logic I_CORE_CLK,
    input wire logic I_RESET,
    input wire logic I_CORE_CE,
    input wire logic [7:0] I_REG_ADDR,
    input wire logic [15:0] I_REG_WDATA,
    input wire logic I_REG_WR,
    input wire logic I_REG_RD,
    input wire logic [15:0] O_REG_RDATA,
    input wire logic [11:0] I_CH_GAIN_WORD,
    input wire logic I_SLOTB_PULSE,
    input wire logic O_SLOTB_REVERSE,
    input wire afc_pkg::afc_slot_s O_SLOTA,
    input wire afc_pkg::afc_slot_s O_SLOTB,
    input wire logic [4:0] O_SLOTB_WINDOW_LENGTH,
    input wire logic [12:0] O_SLOTB_WINDOW_LENGTH_CYC,
    input wire afc_pkg::afc_path_e O_SLOTA_PATH
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (I_RESET);
    function automatic afc_pkg::afc_path_e dec(input logic [15:0] w);
        return w == 16'hada5 ? afc_pkg::AFC_PATH_FULL : w == 16'hae65 ? afc_pkg::AFC_PATH_TIA_BUF
            : w == 16'hb065 ? afc_pkg::AFC_PATH_TIA_DIRECT : afc_pkg::AFC_PATH_RESERVED;
    endfunction : dec
    sequence s_wr;
        I_CORE_CE && I_REG_WR && I_REG_ADDR == 8'h3b;
    endsequence
    sequence s_rd;
        I_CORE_CE && I_REG_RD && !I_REG_WR && I_REG_ADDR == 8'h3b;
    endsequence
    // Host leaves three idle cycles between a write and the next read
    AST_READBACK: assert property (s_wr ##1 (!I_REG_WR) [*3] ##1 s_rd
        |=> O_REG_RDATA == $past(I_REG_WDATA, 5)) else $error("readback differs");
    AST_UNMAPPED: assert property (I_CORE_CE && I_REG_RD && I_REG_ADDR == 8'h00
        |=> O_REG_RDATA == 16'h0000) else $error("unmapped read not zero");
    AST_LEN_CYC: assert property (O_SLOTB_WINDOW_LENGTH_CYC
        == 13'(O_SLOTB_WINDOW_LENGTH) * 13'd40) else $error("window cycles wrong");
    AST_REV_HOLD: assert property (I_CORE_CE && !I_SLOTB_PULSE
        |=> $stable(O_SLOTB_REVERSE)) else $error("polarity moved without pulse");
    AST_PATH: assert property (I_CORE_CE && I_REG_WR && I_REG_ADDR == 8'h43
        |-> ##2 O_SLOTA_PATH == dec($past(I_REG_WDATA, 2))) else $error("path decode wrong");
    AST_RST_DEFAULT: assert property ($fell(I_RESET) |=> O_SLOTB.amp_reference_sel
        == 2'd3 && O_SLOTA_PATH == afc_pkg::AFC_PATH_FULL) else $error("reset decode wrong");
    AST_GAIN_IND: assert property (O_SLOTB.per_channel_gain_on && $stable(I_CH_GAIN_WORD)
        |-> O_SLOTB.gains[7:2] == I_CH_GAIN_WORD[11:6]) else $error("slot b gains wrong");
    AST_GAIN_ALL: assert property (!O_SLOTA.per_channel_gain_on
        |-> O_SLOTA.gains == {4{O_SLOTA.gains[1:0]}}) else $error("slot a shared gain wrong");
endmodule : afc_slot_config_chk
bind afc_slot_config afc_slot_config_chk u_chk (
    .I_CORE_CLK(I_CORE_CLK),
    .I_RESET(I_RESET),
    .I_CORE_CE(I_CORE_CE),
    .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WDATA(I_REG_WDATA),
    .I_REG_WR(I_REG_WR),
    .I_REG_RD(I_REG_RD),
    .O_REG_RDATA(O_REG_RDATA),
    .I_CH_GAIN_WORD(I_CH_GAIN_WORD),
    .I_SLOTB_PULSE(I_SLOTB_PULSE),
    .O_SLOTB_REVERSE(O_SLOTB_REVERSE),
    .O_SLOTA(O_SLOTA),
    .O_SLOTB(O_SLOTB),
    .O_SLOTB_WINDOW_LENGTH(O_SLOTB_WINDOW_LENGTH),
    .O_SLOTB_WINDOW_LENGTH_CYC(O_SLOTB_WINDOW_LENGTH_CYC),
    .O_SLOTA_PATH(O_SLOTA_PATH)
);

// File: verification/tb_top.sv
// Self-checking bench for the slot configuration bank.
// Assumes the host model drives the register port and the bench the rest.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic start = 1'b0;
    logic pulse = 1'b0;
    logic ce = 1'b1;
    logic [11:0] chg = 12'h000;
    logic [7:0] addr;
    logic [15:0] wdata, rdata;
    logic wr, rd, rvalid, rev, mis;
    afc_pkg::afc_slot_s sa, sb;
    afc_pkg::afc_path_e path;
    logic [4:0] wlen;
    logic [10:0] wdly;
    logic [12:0] wcyc;
    int error_cnt = 0;
    int samples_checked = 0;
    always #12.5 clk = ~clk;
    afc_slot_config dut (.I_CORE_CLK(clk), .I_RESET(rst), .I_CORE_CE(ce), .I_REG_ADDR(addr),
        .I_REG_WDATA(wdata), .I_REG_WR(wr), .I_REG_RD(rd), .O_REG_RDATA(rdata),
        .O_REG_RVALID(rvalid), .I_CH_GAIN_WORD(chg), .I_SLOTB_SEQ_START(start),
        .I_SLOTB_PULSE(pulse), .O_SLOTB_REVERSE(rev), .O_SLOTA(sa), .O_SLOTB(sb),
        .O_SLOTB_WINDOW_LENGTH(wlen), .O_SLOTB_WINDOW_DELAY(wdly),
        .O_SLOTB_WINDOW_LENGTH_CYC(wcyc), .O_SLOTA_PATH(path), .O_SLOTA_PATH_MISMATCH(mis));
    afc_host_model u_host (.clk(clk), .rdata(rdata), .rvalid(rvalid), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("[ERR] %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic final_report();
        $display("checked %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic wr_w(input logic [7:0] a, input logic [15:0] d);
        logic [15:0] q;
        u_host.xfer(1'b1, a, d, q);
        repeat (2) @(posedge clk);
        #2;
    endtask : wr_w
    task automatic rd_chk(input logic [7:0] a, input logic [15:0] e);
        logic [15:0] q;
        u_host.xfer(1'b0, a, 16'h0000, q);
        chk("reg", e, q);
    endtask : rd_chk
    task automatic t_reset();
        rd_chk(8'h1d, 16'h0000);
        rd_chk(8'h3b, 16'h2017);
        rd_chk(8'h42, 16'h1c38);
        rd_chk(8'h43, 16'hada5);
        rd_chk(8'h44, 16'h1c38);
        chk("vref", 16'h0003, 16'(sb.amp_reference_sel));
        chk("dly", 16'h0017, 16'(wdly));
        chk("len", 16'h0004, 16'(wlen));
        chk("cyc", 16'd160, 16'(wcyc));
        chk("rev", 16'h0000, 16'(rev));
        chk("path", 16'h0000, 16'(path));
        chk("mis", 16'h0000, 16'(mis));
    endtask : t_reset
    task automatic t_rw();
        wr_w(8'h00, 16'hbeef);
        rd_chk(8'h00, 16'h0000);
        wr_w(8'h3b, 16'hffff);
        rd_chk(8'h3b, 16'hffff);
        chk("cyc", 16'd1240, 16'(wcyc));
        chk("len", 16'h001f, 16'(wlen));
        chk("dly", 16'h07ff, 16'(wdly));
    endtask : t_rw
    task automatic t_pulse();
        logic [3:0] ord = 4'b1011;
        wr_w(8'h1d, {12'h000, ord});
        // Six pulses so the wrap back to pulse 1 is seen
        for (int i = 0; i < 6; i++) begin
            {start, pulse} = {i == 0, 1'b1};
            @(posedge clk);
            #2;
            {start, pulse} = 2'b00;
            chk("rev", 16'(ord[i % 4]), 16'(rev));
            @(posedge clk);
            #2;
        end
        // Restart alone, mid-sequence: next pulse must use bit 0, not bit 2
        {start, pulse} = 2'b10;
        @(posedge clk);
        #2;
        {start, pulse} = 2'b01;
        @(posedge clk);
        #2;
        pulse = 1'b0;
        chk("rev", 16'(ord[0]), 16'(rev));
    endtask : t_pulse
    task automatic t_ce();
        // Write while frozen must not land
        ce = 1'b0;
        wr_w(8'h1d, 16'h000f);
        ce = 1'b1;
        rd_chk(8'h1d, 16'h000b);
    endtask : t_ce
    task automatic t_rerst();
        rst = 1'b1;
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        t_reset();
    endtask : t_rerst
    task automatic t_gain();
        chg = 12'hb5c;
        wr_w(8'h44, 16'h1eda);
        chk("slotb", 16'({8'hb6, 2'b01, 3'b111}), 16'(sb));
        wr_w(8'h44, 16'h1e0b);
        chk("slotb", 16'({8'hff, 2'b00, 3'b010}), 16'(sb));
        wr_w(8'h42, 16'h1c49);
        chk("slota", 16'({8'h71, 2'b00, 3'b001}), 16'(sa));
    endtask : t_gain
    task automatic t_path();
        logic [15:0] code [4] = '{16'hada5, 16'hae65, 16'hb065, 16'h1234};
        for (int i = 0; i < 4; i++) begin
            wr_w(8'h42, i == 1 ? 16'h1cb8 : 16'h1c38);
            wr_w(8'h43, code[i]);
            chk("path", 16'(i), 16'(path));
            chk("mis", 16'h0000, 16'(mis));
        end
        // Path code chosen without the bypass bit
        wr_w(8'h42, 16'h1c38);
        wr_w(8'h43, 16'hae65);
        chk("mis", 16'h0001, 16'(mis));
        // Direct path code chosen with the bypass bit set
        wr_w(8'h42, 16'h1cb8);
        wr_w(8'h43, 16'hb065);
        chk("mis", 16'h0001, 16'(mis));
    endtask : t_path
    initial begin
        repeat (2) @(posedge clk);
        #2;
        rst = 1'b0;
        t_reset();
        t_rw();
        t_pulse();
        t_ce();
        t_gain();
        t_path();
        t_rerst();
        final_report();
    end
    // Whole sequence needs well under 1000 cycles; 4000 leaves margin
    initial begin
        #100000;
        error_cnt++;
        final_report();
    end
endmodule : tb_top
